// >>> logic/pep_pkg.sv
package pep_pkg;
	// *****************************************************************
	// command codes and bus addresses
	// *****************************************************************
	localparam logic [7:0] CMD_ON_OFF_CFG = 8'h02;
	localparam logic [7:0] CMD_FAULT_CLR = 8'h03;
	localparam logic [7:0] CMD_STACK_SEL = 8'h04;
	localparam logic [6:0] ARA_ADDR = 7'h0C;
	// own bus address, value is arbitrary
	localparam logic [6:0] DEV_ADDR_DFLT = 7'h24;
	// *****************************************************************
	// power_on_source_config fields
	// *****************************************************************
	localparam int CFG_RSV_MSB = 7;
	localparam int CFG_RSV_LSB = 5;
	localparam int CFG_PWR_RULE = 4;
	localparam int CFG_CMD = 3;
	localparam int CFG_PIN_OBEY = 2;
	localparam int CFG_POL = 1;
	localparam int CFG_DLY = 0;
	localparam logic [4:0] CFG_RST = 5'h00;
	// *****************************************************************
	// stack_member_select values
	// *****************************************************************
	localparam logic [7:0] STACK_ALL = 8'hFF;
	localparam logic [7:0] STACK_RST = 8'hFF;
	// *****************************************************************
	// status byte layout: low bits follow fault sources, top bit is data fault
	// *****************************************************************
	localparam int STS_SRC_W = 7;
	localparam int STS_CML = 7;
	// *****************************************************************
	// timing
	// *****************************************************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int EN_DEB_NS = 1000;
	localparam int EN_DEB_CYC = (EN_DEB_NS * 1000) / CLK_PERIOD_PS;
	localparam int BUS_FILT_NS = 20;
	localparam int BUS_FILT_CYC = (BUS_FILT_NS * 1000) / CLK_PERIOD_PS;
	// *****************************************************************
	// state types
	// *****************************************************************
	typedef enum logic [1:0] {
		PWR_OFF = 2'b00,
		PWR_RUN = 2'b01,
		PWR_HOLD = 2'b11,
		PWR_FALL = 2'b10
	} pep_pwr_t;
	typedef enum logic [3:0] {
		BUS_IDLE = 4'b0000,
		BUS_ADDR = 4'b0001,
		BUS_ADDR_ACK = 4'b0011,
		BUS_CMD = 4'b0010,
		BUS_CMD_ACK = 4'b0110,
		BUS_DATA = 4'b0111,
		BUS_DATA_ACK = 4'b0101,
		BUS_RD = 4'b0100,
		BUS_RD_ACK = 4'b1100
	} pep_bus_t;
endpackage : pep_pkg

// >>> logic/pep_in_filter.sv
`timescale 1ns/1ps
// two-flop synchroniser followed by a stability filter
module pep_in_filter #(
	parameter int STABLE = 2,
	parameter bit INIT = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pin and filtered level
	input wire logic din,
	output logic dout
);
	logic sync1_r;
	logic sync2_r;
	logic [7:0] cnt_r;

	// synchroniser stages
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_r <= INIT;
			sync2_r <= INIT;
		end else begin
			sync1_r <= din;
			sync2_r <= sync1_r;
		end
	end

	// accept a new level only after it held for STABLE cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 8'h00;
			dout <= INIT;
		end else if (sync2_r == dout) begin
			cnt_r <= 8'h00;
		end else if (cnt_r >= 8'(STABLE - 1)) begin
			cnt_r <= 8'h00;
			dout <= sync2_r;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
endmodule : pep_in_filter

// >>> logic/pep_cmd_top.sv
// Overview of operation
// R01: on/off config bits 7:5 are read-only and read zero.
// R02: power-up rule clear: convert whenever input power present, pin ignored.
// R03: power-up rule set: start/stop only from selected pin and/or command.
// R04: command-obey bit gates the OPERATION on bit.
// R05: pin-obey bit gates the control pin, and its undervoltage use.
// R06: polarity zero means active-low pin without undervoltage use; one active-high.
// R07: delay clear: pin turn-off holds, then ramps down within fall time.
// R08: delay set: pin turn-off stops conversion at once.
// R09: control pin is the enable/undervoltage pin.
// R10: unlisted on/off config value rejected, status flagged, host alerted.
// R11: 02h/04h are write/read byte; 03h is send byte only.
// R12: fault clear clears status of selected phase or all on broadcast.
// R13: fault clear releases the alert line.
// R14: fault clear never restarts a latched-off converter.
// R15: persisting fault re-sets its flag and alerts again.
// R16: alert response answer releases alert, keeps status flags.
// R17: pre-answer sources stay silent until cleared; new sources alert. Code also unblocks them on an off-to-on toggle.
// R18: stack select value targets later phased commands.
// R19: select 0..3 are phases, 4..254 invalid, 255 broadcast; reset broadcast.
// R20: controller strap low is phase 0; followers use position strap.
// R21: select naming phase absent from stack is rejected and flagged.
// R22: OPERATION top bit enables conversion when command control selected.
// R23: pin and command both selected: run only when both active.
// R24: control pin synchronised and debounced before use.
`timescale 1ns/1ps
module pep_cmd_top
	import pep_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = pep_pkg::DEV_ADDR_DFLT
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// serial bus pins, open drain
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_N,
	output logic ALERT_O,
	output logic ALERT_OE_N,
	// straps and nonvolatile defaults
	input wire logic FOLLOWER_STRAP_PIN,
	input wire logic [1:0] STACK_POSITION_STRAP,
	input wire logic [1:0] STACK_LAST,
	input wire logic [4:0] NVM_ON_OFF_CFG,
	// converter side
	input wire logic ENABLE_UNDERVOLT_PIN,
	input wire logic PVIN_OK,
	input wire logic OPERATION_ON,
	input wire logic OPERATION_SOFT_OFF,
	input wire logic FAULT_LATCHED,
	input wire logic [6:0] FAULT_SRC,
	input wire logic [15:0] TOFF_DELAY_CYC,
	input wire logic [15:0] TOFF_FALL_CYC,
	// results
	output logic CONV_RUN,
	output logic RAMP_DOWN,
	output logic UVLO_ACTIVE,
	output logic [7:0] STATUS,
	output logic [7:0] STACK_SELECT,
	output logic [1:0] OWN_PHASE
);
	// *****************************************************************
	// input conditioning
	// *****************************************************************
	logic scl_f;
	logic sda_f;
	logic en_f;
	logic scl_q;
	logic sda_q;

	pep_in_filter #(.STABLE(BUS_FILT_CYC), .INIT(1'b1)) u_scl (
		.clk(CLOCK), .rst(RST), .din(SCL_I), .dout(scl_f));
	pep_in_filter #(.STABLE(BUS_FILT_CYC), .INIT(1'b1)) u_sda (
		.clk(CLOCK), .rst(RST), .din(SDA_I), .dout(sda_f));
	// control pin debounce [R24] [R09]
	pep_in_filter #(.STABLE(EN_DEB_CYC), .INIT(1'b0)) u_en (
		.clk(CLOCK), .rst(RST), .din(ENABLE_UNDERVOLT_PIN), .dout(en_f));

	// previous filtered bus levels for edge finding
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl_rise = scl_f & ~scl_q;
	assign scl_fall = ~scl_f & scl_q;
	assign bus_start = scl_f & scl_q & sda_q & ~sda_f;
	assign bus_stop = scl_f & scl_q & ~sda_q & sda_f;

	// *****************************************************************
	// strap capture and default load after reset release
	// *****************************************************************
	logic init_done_r;
	logic [1:0] own_phase_r;
	logic [4:0] cfg_r;
	logic [7:0] stack_sel_r;

	// controller takes phase 0, followers their position [R20]
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			init_done_r <= 1'b0;
			own_phase_r <= 2'b00;
		end else if (!init_done_r) begin
			init_done_r <= 1'b1;
			own_phase_r <= FOLLOWER_STRAP_PIN ? STACK_POSITION_STRAP : 2'b00;
		end
	end

	// *****************************************************************
	// bus slave state machine
	// *****************************************************************
	pep_bus_t bus_st_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] sh_r;
	logic [7:0] tx_r;
	logic [7:0] cmd_r;
	logic [7:0] data_r;
	logic [1:0] wr_cnt_r;
	logic rd_txn_r;
	logic ara_r;
	logic mack_r;
	logic sda_low_r;
	logic ara_done;
	logic wr_commit;
	logic clr_cmd;
	logic alert_r;
	logic [7:0] rd_byte;

	// read data: reserved config bits read zero [R01] [R11]
	always_comb begin
		rd_byte = 8'h00;
		if (ara_r) begin
			rd_byte = {DEV_ADDR, 1'b0};
		end else if (cmd_r == CMD_ON_OFF_CFG) begin
			rd_byte = {3'b000, cfg_r};
		end else if (cmd_r == CMD_STACK_SEL) begin
			rd_byte = stack_sel_r;
		end
	end

	// transfer ends: commit a byte write or run a send byte [R11]
	assign wr_commit = bus_stop && !rd_txn_r && wr_cnt_r == 2'd2;
	assign clr_cmd = bus_stop && !rd_txn_r && wr_cnt_r == 2'd1 && cmd_r == CMD_FAULT_CLR;
	assign ara_done = ara_r && bus_st_r == BUS_RD_ACK && scl_fall;

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			bus_st_r <= BUS_IDLE;
			bit_cnt_r <= 4'h0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			cmd_r <= 8'h00;
			data_r <= 8'h00;
			wr_cnt_r <= 2'd0;
			rd_txn_r <= 1'b0;
			ara_r <= 1'b0;
			mack_r <= 1'b0;
			sda_low_r <= 1'b0;
		end else if (bus_start) begin
			bus_st_r <= BUS_ADDR;
			bit_cnt_r <= 4'h0;
			sda_low_r <= 1'b0;
			ara_r <= 1'b0;
		end else if (bus_stop) begin
			wr_cnt_r <= 2'd0;
			bus_st_r <= BUS_IDLE;
			sda_low_r <= 1'b0;
			ara_r <= 1'b0;
		end else begin
			unique case (bus_st_r)
				BUS_IDLE: begin
					sda_low_r <= 1'b0;
				end
				BUS_ADDR, BUS_CMD, BUS_DATA: begin
					if (scl_rise) begin
						sh_r <= {sh_r[6:0], sda_f};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == 4'h8) begin
						bit_cnt_r <= 4'h0;
						sda_low_r <= 1'b1;
						if (bus_st_r == BUS_ADDR) begin
							rd_txn_r <= sh_r[0];
							if (sh_r[7:1] == DEV_ADDR) begin
								bus_st_r <= BUS_ADDR_ACK;
								wr_cnt_r <= sh_r[0] ? wr_cnt_r : 2'd0;
							end else if (sh_r == {ARA_ADDR, 1'b1} && alert_r) begin
								bus_st_r <= BUS_ADDR_ACK;
								ara_r <= 1'b1;
							end else begin
								bus_st_r <= BUS_IDLE;
								sda_low_r <= 1'b0;
							end
						end else if (bus_st_r == BUS_CMD) begin
							cmd_r <= sh_r;
							wr_cnt_r <= 2'd1;
							bus_st_r <= BUS_CMD_ACK;
						end else begin
							data_r <= sh_r;
							wr_cnt_r <= 2'd2;
							bus_st_r <= BUS_DATA_ACK;
						end
					end
				end
				BUS_ADDR_ACK, BUS_CMD_ACK, BUS_DATA_ACK: begin
					if (scl_fall) begin
						if (bus_st_r == BUS_ADDR_ACK && rd_txn_r) begin
							tx_r <= rd_byte;
							sda_low_r <= ~rd_byte[7];
							bus_st_r <= BUS_RD;
						end else begin
							sda_low_r <= 1'b0;
							// extra bytes after the data are not acknowledged
							bus_st_r <= (bus_st_r == BUS_ADDR_ACK) ? BUS_CMD :
								(bus_st_r == BUS_CMD_ACK) ? BUS_DATA : BUS_IDLE;
						end
					end
				end
				BUS_RD: begin
					if (scl_rise) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_r == 4'h8) begin
							bit_cnt_r <= 4'h0;
							sda_low_r <= 1'b0;
							bus_st_r <= BUS_RD_ACK;
						end else begin
							tx_r <= {tx_r[6:0], 1'b0};
							sda_low_r <= ~tx_r[6];
						end
					end
				end
				BUS_RD_ACK: begin
					if (scl_rise) begin
						mack_r <= ~sda_f;
					end else if (scl_fall) begin
						if (mack_r && !ara_r) begin
							tx_r <= rd_byte;
							sda_low_r <= ~rd_byte[7];
							bus_st_r <= BUS_RD;
						end else begin
							bus_st_r <= BUS_IDLE;
						end
					end
				end
				default: begin
					bus_st_r <= BUS_IDLE;
					sda_low_r <= 1'b0;
				end
			endcase
		end
	end

	// *****************************************************************
	// register writes and validity checks
	// *****************************************************************
	logic cfg_ok;
	logic sel_ok;
	logic bad_data;
	logic addressed;

	// reserved bits clear and a start source named when rule bit set [R10]
	assign cfg_ok = data_r[CFG_RSV_MSB:CFG_RSV_LSB] == 3'b000
		&& !(data_r[CFG_PWR_RULE] && data_r[CFG_CMD:CFG_PIN_OBEY] == 2'b00);
	// broadcast or a phase present in the stack [R19] [R21]
	assign sel_ok = data_r == STACK_ALL || data_r <= {6'h00, STACK_LAST};
	assign bad_data = wr_commit && ((cmd_r == CMD_ON_OFF_CFG && !cfg_ok)
		|| (cmd_r == CMD_STACK_SEL && !sel_ok) || cmd_r == CMD_FAULT_CLR);
	// phased commands act on this device only when it is selected [R18]
	assign addressed = stack_sel_r == STACK_ALL || stack_sel_r == {6'h00, own_phase_r};

	// on/off config, loaded from nonvolatile defaults after reset
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			cfg_r <= CFG_RST;
		end else if (!init_done_r) begin
			cfg_r <= NVM_ON_OFF_CFG;
		end else if (wr_commit && cmd_r == CMD_ON_OFF_CFG && cfg_ok) begin
			cfg_r <= data_r[CFG_PWR_RULE:0]; // [R01] [R10]
		end
	end

	// stack member select [R18] [R19] [R21]
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			stack_sel_r <= STACK_RST;
		end else if (wr_commit && cmd_r == CMD_STACK_SEL && sel_ok) begin
			stack_sel_r <= data_r;
		end
	end

	// *****************************************************************
	// status flags and alert
	// *****************************************************************
	logic [7:0] status_r;
	logic [7:0] blocked_r;
	logic [7:0] sts_set;
	logic [7:0] sts_nxt;
	logic [7:0] blk_nxt;
	logic fault_clr;
	logic run_rise;

	assign fault_clr = clr_cmd && addressed; // [R12] [R18]
	assign sts_set = {bad_data, FAULT_SRC};
	// clear first, then live sources set again, set wins [R12] [R15]
	assign sts_nxt = (fault_clr ? 8'h00 : status_r) | sts_set;
	// answered sources stay silent until clear or off-on toggle [R17]
	assign blk_nxt = (fault_clr || run_rise) ? 8'h00 : (ara_done ? status_r : blocked_r);

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			status_r <= 8'h00;
			blocked_r <= 8'h00;
			alert_r <= 1'b0;
		end else begin
			status_r <= sts_nxt; // [R16]
			blocked_r <= blk_nxt;
			alert_r <= |(sts_nxt & ~blk_nxt); // [R13] [R10] [R16]
		end
	end

	// *****************************************************************
	// conversion enable and turn-off profile
	// *****************************************************************
	pep_pwr_t pwr_st_r;
	logic [15:0] tcnt_r;
	logic pin_act;
	logic pin_ok;
	logic cmd_ok;
	logic want_run;
	logic run_q;

	// polarity selects active level [R06] [R09]
	assign pin_act = cfg_r[CFG_POL] ? en_f : ~en_f;
	assign pin_ok = !cfg_r[CFG_PIN_OBEY] || pin_act; // [R05]
	assign cmd_ok = !cfg_r[CFG_CMD] || OPERATION_ON; // [R04] [R22]
	// latch-off is owned outside and never cleared here [R14]
	assign want_run = PVIN_OK && !FAULT_LATCHED
		&& (!cfg_r[CFG_PWR_RULE] || (pin_ok && cmd_ok)); // [R02] [R03] [R23]

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			pwr_st_r <= PWR_OFF;
			tcnt_r <= 16'h0000;
		end else begin
			unique case (pwr_st_r)
				PWR_OFF: begin
					if (want_run && init_done_r) begin
						pwr_st_r <= PWR_RUN;
					end
				end
				PWR_RUN: begin
					tcnt_r <= 16'h0000;
					if (!want_run) begin
						if (!PVIN_OK || FAULT_LATCHED) begin
							pwr_st_r <= PWR_OFF;
						end else if (cfg_r[CFG_PWR_RULE] && !pin_ok) begin
							pwr_st_r <= cfg_r[CFG_DLY] ? PWR_OFF : PWR_HOLD; // [R07] [R08]
						end else begin
							pwr_st_r <= OPERATION_SOFT_OFF ? PWR_HOLD : PWR_OFF;
						end
					end
				end
				PWR_HOLD: begin
					if (want_run) begin
						pwr_st_r <= PWR_RUN;
					end else if (!PVIN_OK || FAULT_LATCHED) begin
						pwr_st_r <= PWR_OFF;
					end else if (tcnt_r >= TOFF_DELAY_CYC) begin
						tcnt_r <= 16'h0000;
						pwr_st_r <= PWR_FALL; // [R07]
					end else begin
						tcnt_r <= tcnt_r + 16'h0001;
					end
				end
				PWR_FALL: begin
					if (want_run) begin
						pwr_st_r <= PWR_RUN;
					end else if (!PVIN_OK || FAULT_LATCHED || tcnt_r >= TOFF_FALL_CYC) begin
						pwr_st_r <= PWR_OFF;
					end else begin
						tcnt_r <= tcnt_r + 16'h0001;
					end
				end
			endcase
		end
	end

	// off-to-on toggle marker
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			run_q <= 1'b0;
		end else begin
			run_q <= pwr_st_r == PWR_RUN;
		end
	end
	assign run_rise = pwr_st_r == PWR_RUN && !run_q;

	// *****************************************************************
	// outputs
	// *****************************************************************
	assign SDA_O = 1'b0;
	assign SDA_OE_N = ~sda_low_r;
	assign ALERT_O = 1'b0;
	assign ALERT_OE_N = ~alert_r;
	assign CONV_RUN = pwr_st_r != PWR_OFF;
	assign RAMP_DOWN = pwr_st_r == PWR_FALL;
	assign UVLO_ACTIVE = cfg_r[CFG_PIN_OBEY] && cfg_r[CFG_POL]; // [R05] [R06]
	assign STATUS = status_r;
	assign STACK_SELECT = stack_sel_r;
	assign OWN_PHASE = own_phase_r;

	// *****************************************************************
	// assertions
	// *****************************************************************
	sequence s_pin_off_run;
		pwr_st_r == PWR_RUN && PVIN_OK && !FAULT_LATCHED && cfg_r[CFG_PWR_RULE] && !pin_ok;
	endsequence
	property p_rsv_zero;
		@(posedge CLOCK) disable iff (RST)
		bus_st_r == BUS_RD && !ara_r && cmd_r == CMD_ON_OFF_CFG && bit_cnt_r < 4'h3
		&& !scl_fall |-> sda_low_r;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit read as one"); // [R01]
	property p_free_run;
		@(posedge CLOCK) disable iff (RST)
		init_done_r && !cfg_r[CFG_PWR_RULE] && PVIN_OK && !FAULT_LATCHED [*3] |-> CONV_RUN;
	endproperty
	a_free_run: assert property (p_free_run) else $error("no run with input power"); // [R02]
	property p_pin_fast;
		@(posedge CLOCK) disable iff (RST)
		s_pin_off_run and cfg_r[CFG_DLY] |=> pwr_st_r == PWR_OFF;
	endproperty
	a_pin_fast: assert property (p_pin_fast) else $error("immediate stop missed"); // [R08]
	property p_pin_soft;
		@(posedge CLOCK) disable iff (RST)
		s_pin_off_run and (!cfg_r[CFG_DLY] && TOFF_DELAY_CYC != 16'h0000)
		|=> pwr_st_r == PWR_HOLD ##1 !RAMP_DOWN;
	endproperty
	a_pin_soft: assert property (p_pin_soft) else $error("hold before ramp missed"); // [R07]
	property p_clear;
		@(posedge CLOCK) disable iff (RST)
		fault_clr && sts_set == 8'h00 && !wr_commit |=> status_r == 8'h00 && !alert_r;
	endproperty
	a_clear: assert property (p_clear) else $error("fault clear incomplete"); // [R12]
	property p_ara;
		@(posedge CLOCK) disable iff (RST)
		ara_done && !fault_clr && (sts_set & ~status_r) == 8'h00
		|=> !alert_r && (status_r & $past(status_r)) == $past(status_r);
	endproperty
	a_ara: assert property (p_ara) else $error("alert answer mishandled"); // [R16]
	property p_sel_bad;
		@(posedge CLOCK) disable iff (RST)
		wr_commit && cmd_r == CMD_STACK_SEL && !sel_ok |=> $stable(stack_sel_r) && status_r[STS_CML];
	endproperty
	a_sel_bad: assert property (p_sel_bad) else $error("invalid select accepted"); // [R21]
	property p_both;
		@(posedge CLOCK) disable iff (RST)
		pwr_st_r == PWR_RUN && $past(cfg_r[CFG_PWR_RULE]) && $past(cfg_r[CFG_CMD])
		&& $past(cfg_r[CFG_PIN_OBEY]) |-> $past(OPERATION_ON) && $past(pin_act);
	endproperty
	a_both: assert property (p_both) else $error("run without both sources"); // [R23]
endmodule : pep_cmd_top

// >>> tb/pep_host_model.sv
`timescale 1ns/1ps
// *****************************************************************
// serial bus host, bit-banged with a 125 ns bus clock
// *****************************************************************
module pep_host_model
	import pep_pkg::*;
(
	// bus clock and data pull-down, released line reads high
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	localparam realtime Q = 31.25;
	// idle bus: clock stands high, data released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// start, or repeated start: data released, clock rises after a fixed 2*Q wait without checking the device, then data pulled low
	task automatic start();
		sda_low = 1'b0;
		#(2 * Q) scl = 1'b1;
		#(2 * Q) sda_low = 1'b1;
		#(2 * Q) scl = 1'b0;
	endtask : start
	// stop, then bus free time
	task automatic stop();
		#Q sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#(4 * Q);
	endtask : stop
	// one bit: data set mid-low, sampled mid-high
	task automatic bit_xfer(input logic b, output logic r);
		#Q sda_low = !b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
	endtask : bit_xfer
	// eight bits msb first, ninth bit always released by the host
	task automatic byte_xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], r);
			q[i] = r;
		end
		bit_xfer(1'b1, r);
		ack = !r;
	endtask : byte_xfer
	// write byte, or send byte when no data follows
	task automatic send(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
		input logic has_d, output logic ok);
		logic [7:0] q;
		logic k1, k2, k3;
		k3 = 1'b1;
		start();
		byte_xfer({a, 1'b0}, q, k1);
		byte_xfer(c, q, k2);
		if (has_d) begin
			byte_xfer(d, q, k3);
		end
		stop();
		ok = k1 & k2 & k3;
	endtask : send
	// read byte with repeated start, or alert response when no command
	task automatic fetch(input logic [6:0] a, input logic [7:0] c, input logic has_c,
		output logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic k1, k2, k3, nack;
		k1 = 1'b1;
		k2 = 1'b1;
		start();
		if (has_c) begin
			byte_xfer({a, 1'b0}, q, k1);
			byte_xfer(c, q, k2);
			start();
		end
		byte_xfer({has_c ? a : ARA_ADDR, 1'b1}, q, k3);
		byte_xfer(8'hFF, d, nack);
		stop();
		ok = k1 & k2 & k3;
	endtask : fetch
endmodule : pep_host_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import pep_pkg::*;
	// *****************************************************************
	// board signals
	// *****************************************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic scl, sda_low, sda_o, sda_oe_n, alert_o, alert_oe_n;
	logic strap, en_pin, pvin, op_on, op_soft, latched, conv_run, ramp, uvlo;
	logic [1:0] pos, last, own;
	logic [4:0] nvm;
	logic [6:0] fsrc;
	logic [15:0] tdly, tfall;
	logic [7:0] status, sel;
	logic [7:0] bad_val [3] = '{8'h02, 8'h05, 8'hFE};
	wire sda = !(sda_low || (!sda_oe_n && !sda_o));
	wire alert = alert_oe_n ? 1'b1 : alert_o;
	int bad_count = 0;
	int comparisons = 0;
	// clock
	always #2.5 clk = !clk;
	pep_host_model host (.scl(scl), .sda_low(sda_low), .sda(sda));
	pep_cmd_top dut (
		.CLOCK(clk), .RST(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n),
		.ALERT_O(alert_o), .ALERT_OE_N(alert_oe_n), .FOLLOWER_STRAP_PIN(strap),
		.STACK_POSITION_STRAP(pos), .STACK_LAST(last), .NVM_ON_OFF_CFG(nvm),
		.ENABLE_UNDERVOLT_PIN(en_pin), .PVIN_OK(pvin), .OPERATION_ON(op_on),
		.OPERATION_SOFT_OFF(op_soft), .FAULT_LATCHED(latched), .FAULT_SRC(fsrc),
		.TOFF_DELAY_CYC(tdly), .TOFF_FALL_CYC(tfall), .CONV_RUN(conv_run), .RAMP_DOWN(ramp),
		.UVLO_ACTIVE(uvlo), .STATUS(status), .STACK_SELECT(sel), .OWN_PHASE(own)
	);
	// *****************************************************************
	// helpers
	// *****************************************************************
	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask : settle
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic chk1(input string name, input logic seen, input logic exp);
		check(name, {7'h00, seen}, {7'h00, exp});
	endtask : chk1
	task automatic reg_wr(input logic [7:0] c, input logic [7:0] d, input logic has_d);
		logic ok;
		host.send(DEV_ADDR_DFLT, c, d, has_d, ok);
		chk1("write ack", ok, 1'b1);
		settle(12);
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] c, output logic [7:0] d);
		logic ok;
		host.fetch(DEV_ADDR_DFLT, c, 1'b1, d, ok);
		chk1("read ack", ok, 1'b1);
		settle(4);
	endtask : reg_rd
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	// *****************************************************************
	// tests
	// *****************************************************************
	initial begin
		logic [7:0] d;
		logic ok;
		logic seen;
		int n;
		{strap, pos, last, nvm, en_pin, pvin} = {1'b0, 2'h2, 2'h1, 5'h16, 1'b0, 1'b1};
		{op_on, op_soft, latched, fsrc, tdly, tfall} = {3'h0, 7'h00, 16'h0014, 16'h000A};
		settle(16);
		rst = 1'b0;
		settle(20);
		reg_rd(CMD_STACK_SEL, d);
		check("select reset", d, STACK_RST);
		reg_rd(CMD_ON_OFF_CFG, d);
		check("config reset", d, 8'h16);
		check("own phase", {6'h00, own}, 8'h00);
		chk1("pin low off", conv_run, 1'b0);
		en_pin = 1'b1;
		settle(150);
		chk1("debounce", conv_run, 1'b0);
		settle(70);
		chk1("pin on", conv_run, 1'b1);
		chk1("uvlo on", uvlo, 1'b1);
		en_pin = 1'b0;
		n = 0;
		while (!ramp && n < 600) begin
			settle(1);
			n++;
		end
		chk1("hold first", n >= EN_DEB_CYC + 21, 1'b1);
		n = 0;
		while (ramp && conv_run && n < 60) begin
			settle(1);
			n++;
		end
		check("fall length", n[7:0], tfall[7:0] + 8'h01);
		chk1("off after ramp", conv_run, 1'b0);
		reg_wr(CMD_ON_OFF_CFG, 8'h17, 1'b1);
		en_pin = 1'b1;
		settle(230);
		en_pin = 1'b0;
		seen = 1'b0;
		n = 0;
		while (conv_run && n < 400) begin
			seen |= ramp;
			settle(1);
			n++;
		end
		chk1("hard off", conv_run, 1'b0);
		chk1("no ramp", seen, 1'b0);
		reg_wr(CMD_ON_OFF_CFG, 8'h15, 1'b1);
		settle(20);
		chk1("active low", conv_run, 1'b1);
		chk1("uvlo off", uvlo, 1'b0);
		reg_wr(CMD_ON_OFF_CFG, 8'h1E, 1'b1);
		en_pin = 1'b1;
		settle(230);
		chk1("both, cmd off", conv_run, 1'b0);
		op_on = 1'b1;
		settle(5);
		chk1("both on", conv_run, 1'b1);
		reg_wr(CMD_ON_OFF_CFG, 8'h1A, 1'b1);
		en_pin = 1'b0;
		settle(230);
		chk1("pin ignored", conv_run, 1'b1);
		op_on = 1'b0;
		settle(4);
		chk1("cmd off", conv_run, 1'b0);
		{op_soft, op_on} = 2'b11;
		settle(4);
		op_on = 1'b0;
		settle(4);
		chk1("soft off hold", conv_run, 1'b1);
		settle(40);
		chk1("soft off done", conv_run, 1'b0);
		op_soft = 1'b0;
		reg_wr(CMD_ON_OFF_CFG, 8'h00, 1'b1);
		chk1("power rule off", conv_run, 1'b1);
		pvin = 1'b0;
		settle(4);
		chk1("no input power", conv_run, 1'b0);
		{pvin, latched} = 2'b11;
		reg_wr(CMD_FAULT_CLR, 8'h00, 1'b0);
		chk1("latched stays off", conv_run, 1'b0);
		latched = 1'b0;
		for (int i = 0; i < 2; i++) begin
			reg_wr(CMD_ON_OFF_CFG, i == 0 ? 8'h20 : 8'h10, 1'b1);
			chk1("bad config flag", status[7], 1'b1);
			chk1("bad config alert", alert, 1'b0);
			reg_rd(CMD_ON_OFF_CFG, d);
			check("config kept", d, 8'h00);
			reg_wr(CMD_FAULT_CLR, 8'h00, 1'b0);
			check("cleared", status, 8'h00);
			chk1("alert released", alert, 1'b1);
		end
		reg_wr(CMD_FAULT_CLR, 8'h00, 1'b1);
		chk1("clear with data", status[7], 1'b1);
		reg_wr(CMD_FAULT_CLR, 8'h00, 1'b0);
		fsrc = 7'h01;
		settle(3);
		reg_wr(CMD_FAULT_CLR, 8'h00, 1'b0);
		check("persisting", status, 8'h01);
		chk1("realert", alert, 1'b0);
		host.fetch(DEV_ADDR_DFLT, 8'h00, 1'b0, d, ok);
		chk1("alert answer ack", ok, 1'b1);
		check("alert answer", d, {DEV_ADDR_DFLT, 1'b0});
		settle(20);
		chk1("answer releases", alert, 1'b1);
		check("flags kept", status, 8'h01);
		fsrc = 7'h03;
		settle(3);
		chk1("new source", alert, 1'b0);
		fsrc = 7'h00;
		foreach (bad_val[i]) begin
			reg_wr(CMD_STACK_SEL, bad_val[i], 1'b1);
			check("select kept", sel, STACK_ALL);
			chk1("select flag", status[7], 1'b1);
		end
		reg_wr(CMD_STACK_SEL, 8'h01, 1'b1);
		reg_rd(CMD_STACK_SEL, d);
		check("select 1", d, 8'h01);
		reg_wr(CMD_FAULT_CLR, 8'h00, 1'b0);
		chk1("other phase", status[7], 1'b1);
		reg_wr(CMD_STACK_SEL, 8'h00, 1'b1);
		reg_wr(CMD_FAULT_CLR, 8'h00, 1'b0);
		check("own phase clear", status, 8'h00);
		{strap, rst} = 2'b11;
		settle(2);
		rst = 1'b0;
		settle(4);
		check("follower phase", {6'h00, own}, 8'h02);
		stop_test();
	end
	// watchdog
	initial begin
		#400_000;
		bad_count++;
		stop_test();
	end
endmodule : tb_top
